//--- rtl/fallback_map.svh
// register offsets, field positions, reset values and command codes of the
// limp-home settings bank; definitions only, included by bare name
`ifndef FALLBACK_MAP_SVH
`define FALLBACK_MAP_SVH

`define CH2_IREF_LOW_ADDR    8'h26
`define CH2_IREF_HIGH_ADDR   8'h27
`define CH1_DIM_LOW_ADDR     8'h28
`define CH1_DIM_HIGH_ADDR    8'h29
`define CH2_DIM_LOW_ADDR     8'h2a
`define CH2_DIM_HIGH_ADDR    8'h2b
`define CH1_ON_TIME_ADDR     8'h2c
`define CH2_ON_TIME_ADDR     8'h2d
`define SOFT_RESET_ADDR      8'h2e

`define BYTE_RESET           8'h00
`define TWO_BIT_RESET        2'h0
`define ON_TIME_RESET        6'h07

`define TWO_BIT_MSB          1
`define ON_TIME_MSB          5

`define CMD_RESET_WDOG_OFF   8'hc3
`define CMD_RESET_WDOG_ON    8'hd4

`endif

//--- rtl/fallback_pkg.sv
// types shared by the limp-home settings bank and its users
// assumes fallback_map.svh for all numeric values
`default_nettype none
package fallback_pkg;

  // one register access, taken in a single ref_clk cycle
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } reg_rsp_t;

  // settings as presented to the analog and timing consumers
  typedef struct packed {
    logic [9:0] ch2_fallback_current_ref;
    logic [9:0] ch1_fallback_dim_width;
    logic [9:0] ch2_fallback_dim_width;
    logic [5:0] ch1_fallback_on_time;
    logic [5:0] ch2_fallback_on_time;
  } fallback_cfg_t;

  // one-cycle pulses to the rest of the device after a soft reset command
  typedef struct packed {
    logic defaults;
    logic to_load;
    logic to_detect;
  } soft_reset_evt_t;

  typedef struct packed {
    logic [1:0]      ch2_iref_low;
    logic [7:0]      ch2_iref_high;
    logic [7:0]      ch1_dim_low;
    logic [1:0]      ch1_dim_high;
    logic [7:0]      ch2_dim_low;
    logic [1:0]      ch2_dim_high;
    logic [5:0]      ch1_on_time;
    logic [5:0]      ch2_on_time;
    logic            wdog_en;
    reg_rsp_t        rsp;
    soft_reset_evt_t evt;
  } bank_state_t;

endpackage

`default_nettype wire

//--- rtl/fallback_settings_bank.sv
// limp-home fallback settings bank with the soft reset command register
// assumes a serial front end that presents decoded byte accesses on req,
// synchronous to ref_clk; the power-cycle flag lives elsewhere and is never
// touched by this bank
//
// Summary of operation
// R1: channel 2 current reference bits 9-2 are a full read/write byte at 0x27 resetting to zero.
// R2: channel 1 dim width is 10 bits, low byte at 0x28 and bits 9-8 in bits 1-0 at 0x29.
// R3: channel 2 dim width is built the same way at 0x2a and 0x2b.
// R4: bits 7-2 of both dim width high bytes read zero and only bits 1-0 take writes.
// R5: channel 1 on-time code is six writable bits 5-0 with bits 7-6 reading zero.
// R6: channel 2 has its own six-bit on-time code with bits 7-6 reading zero.
// R7: both on-time registers reset to 0x07, the 437 kHz setting.
// R8: the dim width bytes sit at 0x28 to 0x2b and all reset to 0x00.
// R9: a write-only soft reset command register sits at 0x2e after the on-time bytes.
// R10: a soft reset leaves the power-cycle flag of the third status byte alone.
// R11: writing 0xc3 restores defaults, turns the watchdog off and, stand-alone, sends the enable machines to load.
// R12: writing 0xd4 restores defaults, turns the watchdog on and, stand-alone, sends the enable machines to detect.
// R13: reading the soft reset command register always returns zero.
// R14: channel 2 current reference bits 1-0 sit in bits 1-0 of 0x26 with bits 7-2 reading zero.
// R15: reserved write bits are dropped and each 10-bit setting is its high bits over its low bits.
`timescale 1ns/1ps
`default_nettype none
`include "fallback_map.svh"

module fallback_settings_bank (
  // clock and reset
  input  wire logic                         ref_clk,
  input  wire logic                         resetn,
  // register access from the serial front end
  input  wire fallback_pkg::reg_req_t       req,
  output var  fallback_pkg::reg_rsp_t       rsp,
  // device mode
  input  wire logic                         standalone_mode,
  // settings and soft reset effects
  output var  fallback_pkg::fallback_cfg_t  cfg,
  output var  logic                         watchdog_enable,
  output var  fallback_pkg::soft_reset_evt_t soft_reset_evt
);

  logic rst_meta;
  logic rst_n;

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  fallback_pkg::bank_state_t state;
  fallback_pkg::bank_state_t next_state;

  function automatic logic [7:0] read_byte(input fallback_pkg::bank_state_t s,
                                           input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      `CH2_IREF_LOW_ADDR:  d = {6'h00, s.ch2_iref_low};  // R14
      `CH2_IREF_HIGH_ADDR: d = s.ch2_iref_high;          // R1
      `CH1_DIM_LOW_ADDR:   d = s.ch1_dim_low;            // R2
      `CH1_DIM_HIGH_ADDR:  d = {6'h00, s.ch1_dim_high};  // R4
      `CH2_DIM_LOW_ADDR:   d = s.ch2_dim_low;            // R3
      `CH2_DIM_HIGH_ADDR:  d = {6'h00, s.ch2_dim_high};  // R4
      `CH1_ON_TIME_ADDR:   d = {2'h0, s.ch1_on_time};    // R5
      `CH2_ON_TIME_ADDR:   d = {2'h0, s.ch2_on_time};    // R6
      // write-only command byte and unmapped bytes both read zero
      default:             d = 8'h00;                    // R13
    endcase
    return d;
  endfunction

  function automatic fallback_pkg::bank_state_t restore_defaults(
      input fallback_pkg::bank_state_t s);
    fallback_pkg::bank_state_t r;
    r = s;
    r.ch2_iref_low  = `TWO_BIT_RESET;
    r.ch2_iref_high = `BYTE_RESET;    // R1
    r.ch1_dim_low   = `BYTE_RESET;    // R8
    r.ch1_dim_high  = `TWO_BIT_RESET;
    r.ch2_dim_low   = `BYTE_RESET;
    r.ch2_dim_high  = `TWO_BIT_RESET;
    r.ch1_on_time   = `ON_TIME_RESET; // R7
    r.ch2_on_time   = `ON_TIME_RESET;
    return r;
  endfunction

  logic cmd_off;
  logic cmd_on;

  always_comb begin
    cmd_off = req.wr && req.addr == `SOFT_RESET_ADDR && req.wdata == `CMD_RESET_WDOG_OFF;
    cmd_on  = req.wr && req.addr == `SOFT_RESET_ADDR && req.wdata == `CMD_RESET_WDOG_ON;
    next_state = state;
    next_state.evt = '0;
    // read sees the bank as it stood before any write of the same cycle
    next_state.rsp.valid = req.rd;
    next_state.rsp.data  = req.rd ? read_byte(state, req.addr) : state.rsp.data;
    if (req.wr) begin
      unique case (req.addr)
        `CH2_IREF_LOW_ADDR:  next_state.ch2_iref_low  = req.wdata[`TWO_BIT_MSB:0]; // R15
        `CH2_IREF_HIGH_ADDR: next_state.ch2_iref_high = req.wdata;                 // R1
        `CH1_DIM_LOW_ADDR:   next_state.ch1_dim_low   = req.wdata;                 // R2
        `CH1_DIM_HIGH_ADDR:  next_state.ch1_dim_high  = req.wdata[`TWO_BIT_MSB:0]; // R4
        `CH2_DIM_LOW_ADDR:   next_state.ch2_dim_low   = req.wdata;                 // R3
        `CH2_DIM_HIGH_ADDR:  next_state.ch2_dim_high  = req.wdata[`TWO_BIT_MSB:0]; // R4
        `CH1_ON_TIME_ADDR:   next_state.ch1_on_time   = req.wdata[`ON_TIME_MSB:0]; // R5
        `CH2_ON_TIME_ADDR:   next_state.ch2_on_time   = req.wdata[`ON_TIME_MSB:0]; // R6
        default: ;
      endcase
    end
    // other command values are accepted and do nothing
    if (cmd_off || cmd_on) begin                                                   // R9
      next_state = restore_defaults(next_state);
      next_state.evt.defaults  = 1'b1;
      next_state.wdog_en       = cmd_on;                                           // R12
      next_state.evt.to_load   = cmd_off && standalone_mode;                       // R11
      // clearing the watchdog timeout bits beforehand is the host's duty
      next_state.evt.to_detect = cmd_on && standalone_mode;                        // R12
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      // constants only, so the async branch never depends on live state
      state <= '{ch2_iref_low:  `TWO_BIT_RESET,
                 ch2_iref_high: `BYTE_RESET,
                 ch1_dim_low:   `BYTE_RESET,
                 ch1_dim_high:  `TWO_BIT_RESET,
                 ch2_dim_low:   `BYTE_RESET,
                 ch2_dim_high:  `TWO_BIT_RESET,
                 ch1_on_time:   `ON_TIME_RESET,
                 ch2_on_time:   `ON_TIME_RESET,
                 wdog_en:       1'b0,
                 rsp:           '0,
                 evt:           '0};
    end else begin
      state <= next_state;
    end
  end

  always_comb begin
    rsp = state.rsp;
    cfg.ch2_fallback_current_ref = {state.ch2_iref_high, state.ch2_iref_low}; // R15
    cfg.ch1_fallback_dim_width   = {state.ch1_dim_high, state.ch1_dim_low};   // R2
    cfg.ch2_fallback_dim_width   = {state.ch2_dim_high, state.ch2_dim_low};   // R3
    cfg.ch1_fallback_on_time     = state.ch1_on_time;
    cfg.ch2_fallback_on_time     = state.ch2_on_time;
    watchdog_enable = state.wdog_en;
    // only the defaults, to_load and to_detect pulses leave here; the power-cycle flag has no input
    soft_reset_evt  = state.evt;                                              // R10
  end

  sequence s_cmd_off;
    req.wr && req.addr == `SOFT_RESET_ADDR && req.wdata == `CMD_RESET_WDOG_OFF;
  endsequence

  sequence s_cmd_on;
    req.wr && req.addr == `SOFT_RESET_ADDR && req.wdata == `CMD_RESET_WDOG_ON;
  endsequence

  chk_off_cmd_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n) // R11
    s_cmd_off |=> !watchdog_enable && soft_reset_evt.defaults
      && cfg.ch1_fallback_on_time == 6'h07 && cfg.ch1_fallback_dim_width == 10'h000
      && soft_reset_evt.to_load == $past(standalone_mode) && !soft_reset_evt.to_detect)
    else $error("0xc3 command did not restore defaults or stop the watchdog");

  chk_on_cmd_defaults: assert property (@(posedge ref_clk) disable iff (!rst_n) // R12
    s_cmd_on |=> watchdog_enable && cfg.ch2_fallback_on_time == 6'h07
      && cfg.ch2_fallback_current_ref == 10'h000
      && soft_reset_evt.to_detect == $past(standalone_mode) && !soft_reset_evt.to_load)
    else $error("0xd4 command did not restore defaults or start the watchdog");

  chk_cmd_read_zero: assert property (@(posedge ref_clk) disable iff (!rst_n) // R13
    req.rd && req.addr == `SOFT_RESET_ADDR |=> rsp.valid && rsp.data == 8'h00)
    else $error("command register read returned nonzero");

  chk_dim_high_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R4
    req.rd && (req.addr == `CH1_DIM_HIGH_ADDR || req.addr == `CH2_DIM_HIGH_ADDR)
      |=> rsp.valid && rsp.data[7:2] == 6'h00)
    else $error("dim width high byte reserved bits not zero");

  chk_on_time_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R5
    req.rd && (req.addr == `CH1_ON_TIME_ADDR || req.addr == `CH2_ON_TIME_ADDR)
      |=> rsp.data[7:6] == 2'h0)
    else $error("on-time reserved bits not zero");

  chk_ch1_dim_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R2
    req.wr && req.addr == `CH1_DIM_HIGH_ADDR
      |=> cfg.ch1_fallback_dim_width[9:8] == $past(req.wdata[1:0]))
    else $error("channel 1 dim width high bits not written");

  chk_ch2_dim_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R3
    req.wr && req.addr == `CH2_DIM_LOW_ADDR
      |=> cfg.ch2_fallback_dim_width[7:0] == $past(req.wdata))
    else $error("channel 2 dim width low byte not written");

  chk_iref_readback: assert property (@(posedge ref_clk) disable iff (!rst_n) // R1
    (req.wr && req.addr == `CH2_IREF_HIGH_ADDR) ##1 (!req.wr)
      ##1 (req.rd && req.addr == `CH2_IREF_HIGH_ADDR && !req.wr)
      |=> rsp.data == $past(req.wdata, 3))
    else $error("current reference high byte readback mismatch");

  chk_iref_low_rsvd: assert property (@(posedge ref_clk) disable iff (!rst_n) // R14
    req.rd && req.addr == `CH2_IREF_LOW_ADDR |=> rsp.data[7:2] == 6'h00
      && rsp.data[1:0] == $past(cfg.ch2_fallback_current_ref[1:0]))
    else $error("current reference low byte readback wrong");

  chk_on_time_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // R6
    req.wr && req.addr == `CH2_ON_TIME_ADDR
      |=> cfg.ch2_fallback_on_time == $past(req.wdata[5:0]))
    else $error("channel 2 on-time not written");

endmodule // fallback_settings_bank

`default_nettype wire

//--- sim/reg_host_model.sv
// host side of the settings bank: one byte access per call
// assumes the bank takes req on the rising edge of ref_clk
`timescale 1ns/1ps
`default_nettype none
`include "fallback_map.svh"
module reg_host_model (
  // clock
  input  wire logic                   ref_clk,
  // request to the bank
  output var  fallback_pkg::reg_req_t req
);
  initial req = '0;
  // request held for exactly one taking edge; idle fields flip so stale values never pass
  task automatic access(input logic w, input logic r, input logic [7:0] a,
                        input logic [7:0] d);
    @(posedge ref_clk);
    req <= '{wr: w, rd: r, addr: a, wdata: d};
    @(posedge ref_clk);
    req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
  endtask
  task automatic command(input logic [7:0] code);
    access(1'b1, 1'b0, `SOFT_RESET_ADDR, code);
  endtask
endmodule // reg_host_model
`default_nettype wire

//--- sim/limp_home_setting_and_soft_reset_regs_tb_top.sv
// self-checking bench for the limp-home settings bank
// assumes the host model drives req; reads are checked from a queue
`timescale 1ns/1ps
`default_nettype none
module limp_home_setting_and_soft_reset_regs_tb_top;
  logic                            ref_clk = 1'b0;
  logic                            resetn = 1'b0;
  logic                            standalone_mode = 1'b0;
  fallback_pkg::reg_req_t          req;
  fallback_pkg::reg_rsp_t          rsp;
  fallback_pkg::fallback_cfg_t     cfg;
  logic                            watchdog_enable;
  fallback_pkg::soft_reset_evt_t   soft_reset_evt;
  logic [7:0]                      exp_q[$];
  logic [7:0]                      e, r0, r1, code;
  integer                          errors = 0;
  integer                          cmp_count = 0;
  integer                          seed = 17517;
  integer                          i;
  localparam logic [41:0] CFG_DEF = {30'h0, 6'h07, 6'h07};
  always #10 ref_clk = ~ref_clk;
  fallback_settings_bank dut_u (.ref_clk(ref_clk), .resetn(resetn), .req(req), .rsp(rsp),
    .standalone_mode(standalone_mode), .cfg(cfg), .watchdog_enable(watchdog_enable),
    .soft_reset_evt(soft_reset_evt));
  reg_host_model host_u (.ref_clk(ref_clk), .req(req));
  task automatic cmp_out(input logic [47:0] got, input logic [47:0] exp);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      errors = errors + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    cmp_out({40'h0, got}, {40'h0, exp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host_u.access(1'b0, 1'b1, a, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host_u.access(1'b1, 1'b0, a, d);
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // read results land one cycle after the taking edge
  always @(posedge ref_clk) begin
    if (rsp.valid === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      cmp_rd(rsp.data, e);
    end
  end
  initial begin
    #200000;
    errors = errors + 1;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1 cmp_out(48'(cfg), 48'(CFG_DEF));
    cmp_out(48'(watchdog_enable), 48'h0);
    for (i = 8'h26; i <= 8'h30; i++)
      rd(i[7:0], (i == 8'h2c || i == 8'h2d) ? 8'h07 : 8'h00);
    for (i = 8'h26; i <= 8'h2d; i++)
      wr(i[7:0], 8'hff);
    #1 cmp_out(48'(cfg), 48'h3ffffffffff);
    for (i = 8'h26; i <= 8'h2d; i++)
      rd(i[7:0], (i == 8'h26 || i == 8'h29 || i == 8'h2b) ? 8'h03 :
        (i >= 8'h2c) ? 8'h3f : 8'hff);
    repeat (8) begin
      r0 = 8'($random(seed));
      r1 = 8'($random(seed));
      wr(8'h28, r0);
      wr(8'h29, r1);
      wr(8'h2a, r1);
      wr(8'h2b, r0);
      #1 cmp_out(48'(cfg.ch1_fallback_dim_width), 48'({r1[1:0], r0}));
      cmp_out(48'(cfg.ch2_fallback_dim_width), 48'({r0[1:0], r1}));
      wr(8'h27, r0);
      rd(8'h27, r0);
    end
    // same-cycle write and read returns the value before the write
    exp_q.push_back(8'h3f);
    host_u.access(1'b1, 1'b1, 8'h2c, 8'hd5);
    rd(8'h2c, 8'h15);
    host_u.command(8'h55);
    #1 cmp_out(48'({soft_reset_evt, cfg.ch1_fallback_on_time}), 48'h15);
    for (i = 0; i < 4; i++) begin
      code = i[1] ? 8'hc3 : 8'hd4;
      @(posedge ref_clk);
      standalone_mode <= i[0];
      wr(8'h28, 8'ha5);
      host_u.command(code);
      #1 cmp_out(48'(soft_reset_evt),
        48'({1'b1, code == 8'hc3 && i[0], code == 8'hd4 && i[0]}));
      cmp_out(48'(watchdog_enable), 48'(code == 8'hd4));
      cmp_out(48'(cfg), 48'(CFG_DEF));
      @(posedge ref_clk);
      #1 cmp_out(48'(soft_reset_evt), 48'h0);
    end
    // mid-run reset must drop the watchdog and all settings at once
    host_u.command(8'hd4);
    wr(8'h2c, 8'h2a);
    @(posedge ref_clk);
    resetn <= 1'b0;
    @(posedge ref_clk);
    #1 cmp_out(48'({watchdog_enable, cfg}), 48'(CFG_DEF));
    @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    rd(8'h2e, 8'h00);
    repeat (3) @(posedge ref_clk);
    cmp_out(48'(exp_q.size()), 48'h0);
    end_of_test();
  end
endmodule // limp_home_setting_and_soft_reset_regs_tb_top
`default_nettype wire
